// *** inc/sts_defs.vh ***
`ifndef STS_DEFS_VH
`define STS_DEFS_VH
`define STS_CLK_MHZ        100
`define STS_SC_FILTER_US   2000
`define STS_SC_CYCLES      (`STS_SC_FILTER_US * `STS_CLK_MHZ)
`define STS_RD_US          10
`define STS_RD_CYCLES      (`STS_RD_US * `STS_CLK_MHZ)
`define STS_CNT_W          18
`define STS_CAN_FAIL_OT    2'h1
`define STS_CAN_FAIL_NONE  2'h0
`endif

// *** rtl/sts_supervisor.v ***
`timescale 1ns/1ns
`include "sts_defs.vh"
module sts_supervisor #(
  parameter SC_CYCLES = `STS_SC_CYCLES,
  parameter RD_CYCLES = `STS_RD_CYCLES
) (
  // clock and reset
  input  wire       clock,
  input  wire       srst,
  // comparators (asynchronous)
  input  wire       supply_por_ok,
  input  wire       supply_uv,
  input  wire       supply_ov,
  input  wire       main_below_rst,
  input  wire       main_below_rt1,
  input  wire       main_ov,
  input  wire       main_prewarn,
  input  wire       main_peak_load,
  input  wire       second_uv,
  input  wire       can_supply_uv,
  input  wire       second_ot,
  input  wire       can_ot,
  input  wire       thermal_prewarn,
  input  wire       charge_pump_on,
  input  wire       can_wake,
  input  wire       hv_wake,
  input  wire       gpio_wake,
  // control from register logic (same clock)
  input  wire       gpio_is_wake_input,
  input  wire       rst_hys_en,
  input  wire       cfg_restart,
  input  wire       req_normal,
  input  wire       req_stop,
  input  wire       req_sleep,
  input  wire       wr_wake_start,
  input  wire       wake_start_val,
  input  wire       wr_ov_rst,
  input  wire       ov_rst_val,
  input  wire       second_on_set,
  input  wire       can_on_set,
  input  wire       can_on_clr,
  input  wire       wd_disabled,
  input  wire [9:0] flag_clr,
  // outputs
  output reg        reset_n_q,
  output reg        fail_output_q,
  output reg        failure_q,
  output reg        main_reg_on_q,
  output reg        second_reg_on_control_q,
  output reg        can_on_q,
  output reg        can_tx_en_q,
  output reg        can_rx_low_q,
  output reg        irq_q,
  output reg        wd_restart_q,
  output reg        bus_wake_watchdog_start_q,
  output reg        main_reg_overvoltage_reset_en_q,
  output reg  [1:0] can_fail_q,
  output reg  [4:0] mode_q,
  output reg  [9:0] flags_q
);
  // mode codes, one-hot
  localparam [4:0] M_INIT = 5'h01, M_NORMAL = 5'h02, M_STOP = 5'h04;
  localparam [4:0] M_RESTART = 5'h08, M_FAILSAFE = 5'h10;
  // flag positions
  localparam POR = 0, SUV = 1, SOV = 2, MWARN = 3, MUV = 4, MOV = 5;
  localparam MSC = 6, SUV2 = 7, CUV = 8, TSD = 9;
  localparam TPWF = 0;

  wire [16:0] s;
  sts_sync #(.W(17)) u_sync (
    .clock (clock),
    .srst  (srst),
    .din   ({supply_por_ok, supply_uv, supply_ov, main_below_rst, main_below_rt1,
             main_ov, main_prewarn, main_peak_load, second_uv, can_supply_uv,
             second_ot, can_ot, thermal_prewarn, charge_pump_on, can_wake,
             hv_wake, gpio_wake}),
    .dout  (s)
  );
  wire por_ok = s[16];
  wire s_uv = s[15];
  wire s_ov = s[14];
  wire m_brst = s[13];
  wire m_brt1 = s[12];
  wire m_ov = s[11];
  wire m_pw = s[10];
  wire m_pk = s[9];
  wire v2_uv = s[8];
  wire vc_uv = s[7];
  wire v2_ot = s[6];
  wire c_ot = s[5];
  wire t_pw = s[4];
  wire cp_on = s[3];
  wire w_can = s[2];
  wire w_hv = s[1];
  wire w_gp = s[0];

  // extra sticky flag for thermal prewarning kept apart from the ten-bit group
  reg        tpw_q;
  reg        sleep_q;
  reg        ov_pend_q;
  reg        sc_trip_q;
  reg        muv_pend_q;
  reg        v2_blank_q;
  reg        w_can_q;
  reg [`STS_CNT_W-1:0] sc_cnt_q;
  reg [`STS_CNT_W-1:0] rd_cnt_q;
  reg [`STS_CNT_W-1:0] bl_cnt_q;

  // set beats clear; conditional flags refuse a clear while the cause stands
  function f_sticky;
    input cur;
    input set;
    input clr;
    input cond_gone;
    begin
      f_sticky = set | (cur & ~(clr & cond_gone));
    end
  endfunction

  wire run_mode = (mode_q == M_INIT) || (mode_q == M_RESTART) || (mode_q == M_NORMAL);
  wire stop_mon = (mode_q == M_STOP) && (m_pk || m_pw);
  wire vs_mon = run_mode || stop_mon;
  wire supply_overvoltage_flag_mon = vs_mon || cp_on;
  wire main_act = main_reg_on_q && !sleep_q;
  // release level: with hysteresis the highest rising threshold governs
  wire main_low = rst_hys_en ? m_brt1 : m_brst;
  wire sc_arm = main_act && !s_uv;
  wire sc_hit = sc_arm && m_brst && (sc_cnt_q >= SC_CYCLES[`STS_CNT_W-1:0] - 1'b1);
  wire ov_go = main_act && m_ov && main_reg_overvoltage_reset_en_q && run_mode;
  wire can_wake_ev = w_can && !w_can_q;
  wire fs_wake = can_wake_ev || w_hv || (w_gp && gpio_is_wake_input);
  wire rd_done = (rd_cnt_q >= RD_CYCLES[`STS_CNT_W-1:0] - 1'b1);
  wire v2_ok = second_reg_on_control_q && (bl_cnt_q == {`STS_CNT_W{1'b0}});

  always @(posedge clock) begin
    if (srst || !por_ok) begin
      mode_q <= M_INIT;
      flags_q <= 10'h001;
      tpw_q <= 1'b0;
      reset_n_q <= 1'b0;
      fail_output_q <= 1'b0;
      failure_q <= 1'b0;
      main_reg_on_q <= 1'b1;
      second_reg_on_control_q <= 1'b0;
      can_on_q <= 1'b0;
      can_tx_en_q <= 1'b0;
      can_rx_low_q <= 1'b0;
      irq_q <= 1'b0;
      wd_restart_q <= 1'b0;
      bus_wake_watchdog_start_q <= 1'b1;
      main_reg_overvoltage_reset_en_q <= 1'b0;
      can_fail_q <= `STS_CAN_FAIL_NONE;
      sleep_q <= 1'b0;
      ov_pend_q <= 1'b0;
      sc_trip_q <= 1'b0;
      muv_pend_q <= 1'b0;
      v2_blank_q <= 1'b0;
      w_can_q <= 1'b0;
      sc_cnt_q <= {`STS_CNT_W{1'b0}};
      rd_cnt_q <= {`STS_CNT_W{1'b0}};
      bl_cnt_q <= {`STS_CNT_W{1'b0}};
    end else begin
      w_can_q <= w_can;
      irq_q <= 1'b0;
      wd_restart_q <= 1'b0;
      flags_q[POR] <= f_sticky(flags_q[POR], 1'b0, flag_clr[POR], 1'b1);
      flags_q[SUV] <= f_sticky(flags_q[SUV], vs_mon && s_uv, flag_clr[SUV], !s_uv);
      flags_q[SOV] <= f_sticky(flags_q[SOV], supply_overvoltage_flag_mon && s_ov, flag_clr[SOV],
                               !s_ov || !cp_on);
      flags_q[MWARN] <= f_sticky(flags_q[MWARN], main_act && m_pw, flag_clr[MWARN], 1'b1);
      flags_q[MUV] <= f_sticky(flags_q[MUV], 1'b0, flag_clr[MUV], 1'b1);
      flags_q[MOV] <= f_sticky(flags_q[MOV], main_act && m_ov, flag_clr[MOV], 1'b1);
      flags_q[MSC] <= f_sticky(flags_q[MSC], sc_hit, flag_clr[MSC], 1'b1);
      flags_q[SUV2] <= f_sticky(flags_q[SUV2], v2_ok && v2_uv, flag_clr[SUV2], 1'b1);
      flags_q[CUV] <= f_sticky(flags_q[CUV], can_on_q && vc_uv, flag_clr[CUV], 1'b1);
      flags_q[TSD] <= f_sticky(flags_q[TSD],
                               (second_reg_on_control_q && v2_ot) || (can_on_q && c_ot),
                               flag_clr[TSD], !v2_ot && !c_ot);
      tpw_q <= f_sticky(tpw_q, t_pw, flag_clr[TSD] && flag_clr[POR], !t_pw);
      // blanking for the second regulator after it turns on
      if (second_on_set && !second_reg_on_control_q) begin
        bl_cnt_q <= SC_CYCLES[`STS_CNT_W-1:0];
      end else if (bl_cnt_q != {`STS_CNT_W{1'b0}}) begin
        bl_cnt_q <= bl_cnt_q - 1'b1;
      end
      if (second_reg_on_control_q && v2_ot) begin
        second_reg_on_control_q <= 1'b0;
      end else if (second_on_set && mode_q == M_NORMAL) begin
        second_reg_on_control_q <= 1'b1;
      end
      if (can_on_set) begin
        can_on_q <= 1'b1;
      end else if (can_on_clr) begin
        can_on_q <= 1'b0;
      end
      can_tx_en_q <= can_on_q && !c_ot;
      if (can_on_q && c_ot) begin
        can_fail_q <= `STS_CAN_FAIL_OT;
      end
      if (mode_q == M_NORMAL && wr_wake_start) begin
        bus_wake_watchdog_start_q <= wake_start_val;
      end
      if (wr_ov_rst && mode_q == M_NORMAL) begin
        main_reg_overvoltage_reset_en_q <= ov_rst_val;
      end
      // short filter counts while low; the second regulator blanking loads the same length
      if (sc_arm && m_brst && !sc_hit) begin
        sc_cnt_q <= sc_cnt_q + 1'b1;
      end else begin
        sc_cnt_q <= {`STS_CNT_W{1'b0}};
      end
      case (mode_q)
        M_INIT, M_NORMAL: begin
          if (mode_q == M_INIT && !reset_n_q) begin
            // hold reset until the highest rising threshold and the delay
            if (m_brt1) begin
              rd_cnt_q <= {`STS_CNT_W{1'b0}};
            end else if (rd_done) begin
              reset_n_q <= 1'b1;
              mode_q <= M_NORMAL;
            end else begin
              rd_cnt_q <= rd_cnt_q + 1'b1;
            end
          end
          if (ov_go) begin
            fail_output_q <= 1'b1;
            reset_n_q <= 1'b0;
            if (cfg_restart) begin
              ov_pend_q <= 1'b1;
              rd_cnt_q <= {`STS_CNT_W{1'b0}};
              mode_q <= M_RESTART;
            end else begin
              mode_q <= M_FAILSAFE;
            end
          end else if (reset_n_q && main_act && m_brst) begin
            reset_n_q <= 1'b0;
            muv_pend_q <= 1'b1;
            rd_cnt_q <= {`STS_CNT_W{1'b0}};
            mode_q <= M_RESTART;
          end else if (mode_q == M_NORMAL && req_stop) begin
            mode_q <= M_STOP;
          end else if (mode_q == M_NORMAL && req_sleep) begin
            sleep_q <= 1'b1;
          end
        end
        M_STOP: begin
          if (can_wake_ev) begin
            irq_q <= 1'b1;
            can_rx_low_q <= 1'b1;
            if (bus_wake_watchdog_start_q && wd_disabled) begin
              wd_restart_q <= 1'b1;
            end
          end
          if (req_normal) begin
            can_rx_low_q <= 1'b0;
            mode_q <= M_NORMAL;
          end
        end
        M_RESTART: begin
          if (ov_pend_q) begin
            if (rd_done) begin
              ov_pend_q <= 1'b0;
              main_reg_overvoltage_reset_en_q <= 1'b0;
              reset_n_q <= 1'b1;
              mode_q <= M_NORMAL;
            end else begin
              rd_cnt_q <= rd_cnt_q + 1'b1;
            end
          end else if (main_low) begin
            rd_cnt_q <= {`STS_CNT_W{1'b0}};
          end else if (rd_done) begin
            reset_n_q <= 1'b1;
            if (muv_pend_q) begin
              flags_q[MUV] <= 1'b1;
            end
            muv_pend_q <= 1'b0;
            mode_q <= M_NORMAL;
          end else begin
            rd_cnt_q <= rd_cnt_q + 1'b1;
          end
        end
        M_FAILSAFE: begin
          // only a short entry is left by a wake; overvoltage fail-safe waits for reset
          if (fs_wake && sc_trip_q) begin
            sc_trip_q <= 1'b0;
            main_reg_on_q <= 1'b1;
            fail_output_q <= 1'b0;
            rd_cnt_q <= {`STS_CNT_W{1'b0}};
            mode_q <= M_RESTART;
          end
        end
        default: begin
          mode_q <= M_INIT;
        end
      endcase
      // last so it wins in every powered mode: an undervoltage restart keeps
      // the output low and would otherwise sit in restart with the filter expired
      if (sc_hit) begin
        sc_trip_q <= 1'b1;
        main_reg_on_q <= 1'b0;
        fail_output_q <= 1'b1;
        failure_q <= 1'b1;
        reset_n_q <= 1'b0;
        mode_q <= M_FAILSAFE;
      end
    end
  end
endmodule // sts_supervisor

// *** rtl/sts_sync.v ***
`timescale 1ns/1ns
// two-flop synchroniser for a bus of asynchronous comparator levels
module sts_sync #(
  parameter W = 1
) (
  // clock and reset
  input  wire         clock,
  input  wire         srst,
  // levels
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] meta_q;

  always @(posedge clock) begin
    if (srst) begin
      meta_q <= {W{1'b0}};
      dout   <= {W{1'b0}};
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule // sts_sync

// *** testbench/sts_host_model.sv ***
`timescale 1ns/1ns
// host side: claims normal mode after each reset release and after a bus wake
module sts_host_model (
  // clock
  input  wire  clock,
  // supervisor outputs
  input  wire  reset_n_q,
  input  wire  irq_q,
  input  wire  can_rx_low_q,
  // mode request
  output logic req_normal
);
  logic rst_seen_q;
  initial req_normal = 1'b0;
  initial rst_seen_q = 1'b0;
  always @(negedge clock) begin
    rst_seen_q <= reset_n_q;
    // a wake with the wake start bit set leaves the watchdog running, so normal mode is claimed at once
    req_normal <= (reset_n_q && !rst_seen_q) || (irq_q && can_rx_low_q);
  end
endmodule // sts_host_model

// *** testbench/sts_supervisor_props.sv ***
`timescale 1ns/1ns
module sts_supervisor_props #(
  parameter SC_CYCLES = 20
) (
  // clock and reset
  input wire       clock,
  input wire       srst,
  // causes
  input wire       main_ov,
  input wire       main_below_rst,
  input wire       supply_uv,
  input wire       can_ot,
  input wire       second_ot,
  input wire       cfg_restart,
  // responses
  input wire       main_reg_on_q,
  input wire       fail_output_q,
  input wire       can_rx_low_q,
  input wire       irq_q,
  input wire       wd_restart_q,
  input wire       bus_wake_watchdog_start_q,
  input wire       main_reg_overvoltage_reset_en_q,
  input wire       can_tx_en_q,
  input wire       second_reg_on_control_q,
  input wire [1:0] can_fail_q,
  input wire [4:0] mode_q,
  input wire [9:0] flags_q
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  // raw low cycles while the trip is armed; the margin covers the synchroniser
  logic [17:0] sc_q;
  wire  [17:0] sc_d = (main_below_rst && main_reg_on_q && !supply_uv) ? sc_q + 18'h00001 : 18'h00000;
  always @(posedge clock) begin
    if (srst) sc_q <= 18'h00000;
    else sc_q <= sc_d;
  end
  a_rx_low_irq: assert property ($rose(can_rx_low_q) |-> irq_q)
    else $error("receive line low without interrupt");
  a_wake_restart: assert property (wd_restart_q |-> irq_q && bus_wake_watchdog_start_q)
    else $error("watchdog restart without wake or start bit");
  a_start_mode: assert property ($changed(bus_wake_watchdog_start_q) |-> $past(mode_q) == 5'h02)
    else $error("wake start bit changed outside normal mode");
  a_ov_flag: assert property ($rose(main_ov) && main_reg_on_q |-> ##[1:5] flags_q[5])
    else $error("main overvoltage flag not set");
  a_ov_restart: assert property ($rose(main_ov) && main_reg_overvoltage_reset_en_q && cfg_restart
    && mode_q == 5'h02 |-> ##[1:6] (mode_q == 5'h08 && fail_output_q))
    else $error("overvoltage did not restart");
  a_ov_failsafe: assert property ($rose(main_ov) && main_reg_overvoltage_reset_en_q && !cfg_restart
    && mode_q == 5'h02 |-> ##[1:6] (mode_q == 5'h10 && fail_output_q))
    else $error("overvoltage did not enter fail-safe");
  a_short_bound: assert property (sc_q <= SC_CYCLES + 5)
    else $error("main regulator short not tripped in time");
  a_can_ot: assert property ($rose(can_ot) && can_tx_en_q
    |-> ##[1:5] (!can_tx_en_q && can_fail_q == 2'h1))
    else $error("transmitter not disabled on overtemperature");
  a_second_ot: assert property ($rose(second_ot) && second_reg_on_control_q
    |-> ##[1:5] !second_reg_on_control_q)
    else $error("second regulator not switched off");
  c_bus_wake: cover property (wd_restart_q);
  c_short: cover property (mode_q == 5'h10 && flags_q[6]);
  c_can_ot: cover property (can_fail_q == 2'h1);
endmodule // sts_supervisor_props
bind sts_supervisor sts_supervisor_props #(.SC_CYCLES(SC_CYCLES)) chk_u (.*);

// *** testbench/testbench.sv ***
`timescale 1ns/1ns
module testbench;
  localparam SC = 20;
  localparam RD = 10;
  logic clock, srst, supply_por_ok, supply_uv, supply_ov, main_below_rst, main_below_rt1;
  logic main_ov, main_prewarn, main_peak_load, second_uv, can_supply_uv, second_ot, can_ot;
  logic thermal_prewarn, charge_pump_on, can_wake, hv_wake, gpio_wake, gpio_is_wake_input;
  logic rst_hys_en, cfg_restart, req_normal, req_stop, req_sleep, wr_wake_start, wake_start_val;
  logic wr_ov_rst, ov_rst_val, second_on_set, can_on_set, can_on_clr, wd_disabled;
  logic reset_n_q, fail_output_q, failure_q, main_reg_on_q, second_reg_on_control_q, can_on_q;
  logic can_tx_en_q, can_rx_low_q, irq_q, wd_restart_q, bus_wake_watchdog_start_q;
  logic main_reg_overvoltage_reset_en_q, rxl, wdr;
  logic [1:0] can_fail_q;
  logic [4:0] mode_q;
  logic [9:0] flag_clr, flags_q, clr, old;
  logic [31:0] seed = 32'h00009F84;
  int mismatches = 0;
  int n_checks = 0;
  sts_supervisor #(.SC_CYCLES(SC), .RD_CYCLES(RD)) dut_u (.*);
  sts_host_model host_u (.*);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (can_rx_low_q === 1'b1) rxl <= 1'b1;
    if (wd_restart_q === 1'b1) wdr <= 1'b1;
  end
  function automatic logic [9:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[9:0];
  endfunction
  // supply undervoltage is still present, so its flag survives the clear
  function automatic logic [9:0] exp_clr(input logic [9:0] f, input logic [9:0] c);
    return (f & ~c) | (f & 10'h002);
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(1);
  endtask
  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic boot();
    main_below_rt1 = 1'b1;
    srst = 1'b1;
    cyc(10);
    chk("mode", 5'h01, mode_q);
    chk("flags", 10'h001, flags_q);
    chk("wake_start", 1'h1, bus_wake_watchdog_start_q);
    srst = 1'b0;
    cyc(2);
    main_below_rt1 = 1'b0;
    cyc(RD);
    chk("reset_n", 1'h0, reset_n_q);
    cyc(10);
    chk("reset_n", 1'h1, reset_n_q);
    cyc(3);
  endtask
  initial begin
    {supply_uv, supply_ov, main_below_rst, main_ov, main_prewarn, main_peak_load, second_uv,
     can_supply_uv, second_ot, can_ot, thermal_prewarn, charge_pump_on, can_wake, hv_wake,
     gpio_wake, gpio_is_wake_input, rst_hys_en, cfg_restart, req_stop, req_sleep, wr_wake_start,
     wake_start_val, wr_ov_rst, ov_rst_val, second_on_set, can_on_set, can_on_clr, wd_disabled,
     flag_clr, rxl, wdr} = '0;
    supply_por_ok = 1'b1;
    boot();
    supply_uv = 1'b1;
    cyc(5);
    chk("flags", 10'h003, flags_q);
    clr = xs() | 10'h002;
    old = flags_q;
    flag_clr = clr;
    cyc(1);
    flag_clr = 10'h000;
    cyc(1);
    chk("flags", exp_clr(old, clr), flags_q);
    supply_uv = 1'b0;
    cyc(5);
    flag_clr = 10'h002;
    cyc(1);
    flag_clr = 10'h000;
    cyc(1);
    chk("supply_uv", 1'h0, flags_q[1]);
    for (int c = 1; c >= 0; c--) begin
      cfg_restart = c[0];
      ov_rst_val = 1'b1;
      pulse(wr_ov_rst);
      main_ov = 1'b1;
      cyc(6);
      chk("ov_mode", c ? 5'h08 : 5'h10, mode_q);
      chk("fail_out", 1'h1, fail_output_q);
      chk("ov_flag", 1'h1, flags_q[5]);
      cyc(RD + 6);
      main_ov = 1'b0;
      if (c) chk("ov_rst_en", 1'h0, main_reg_overvoltage_reset_en_q);
      if (c) chk("ov_mode", 5'h02, mode_q);
      boot();
    end
    main_below_rst = 1'b1;
    cyc(SC + 10);
    chk("sc_mode", 5'h10, mode_q);
    chk("sc_flag", 1'h1, flags_q[6]);
    chk("reg_on", 1'h0, main_reg_on_q);
    chk("failure", 1'h1, failure_q);
    main_below_rst = 1'b0;
    can_wake = 1'b1;
    cyc(6);
    can_wake = 1'b0;
    chk("fs_exit", 1'h1, mode_q !== 5'h10);
    boot();
    wd_disabled = 1'b1;
    pulse(req_stop);
    chk("mode", 5'h04, mode_q);
    wake_start_val = 1'b0;
    pulse(wr_wake_start);
    chk("wake_start", 1'h1, bus_wake_watchdog_start_q);
    supply_uv = 1'b1;
    cyc(4);
    chk("supply_uv", 1'h0, flags_q[1]);
    main_peak_load = 1'b1;
    cyc(4);
    chk("supply_uv", 1'h1, flags_q[1]);
    {supply_uv, main_peak_load} = 2'b00;
    rxl = 1'b0;
    wdr = 1'b0;
    can_wake = 1'b1;
    cyc(6);
    can_wake = 1'b0;
    chk("rx_low", 1'h1, rxl);
    chk("wd_restart", 1'h1, wdr);
    cyc(2);
    chk("mode", 5'h02, mode_q);
    chk("rx_low", 1'h0, can_rx_low_q);
    pulse(can_on_set);
    pulse(second_on_set);
    chk("tx_en", 1'h1, can_tx_en_q);
    can_ot = 1'b1;
    second_ot = 1'b1;
    cyc(5);
    chk("tx_en", 1'h0, can_tx_en_q);
    chk("can_fail", 2'h1, can_fail_q);
    chk("second_on", 1'h0, second_reg_on_control_q);
    chk("tsd_flag", 1'h1, flags_q[9]);
    can_ot = 1'b0;
    second_ot = 1'b0;
    cyc(5);
    chk("tx_en", 1'h1, can_tx_en_q);
    chk("second_on", 1'h0, second_reg_on_control_q);
    chk("can_on", 1'h1, can_on_q);
    {can_supply_uv, main_prewarn} = 2'b11;
    cyc(4);
    chk("flags", 10'h30B, flags_q);
    flag_clr = 10'h3FF;
    cyc(1);
    flag_clr = 10'h000;
    cyc(1);
    chk("flags", 10'h108, flags_q);
    {can_supply_uv, main_prewarn} = 2'b00;
    cyc(4);
    flag_clr = 10'h3FF;
    cyc(1);
    flag_clr = 10'h000;
    cyc(1);
    chk("flags", 10'h000, flags_q);
    wake_start_val = 1'b0;
    pulse(wr_wake_start);
    chk("wake_start", 1'h0, bus_wake_watchdog_start_q);
    wake_start_val = 1'b1;
    pulse(wr_wake_start);
    chk("wake_start", 1'h1, bus_wake_watchdog_start_q);
    pulse(can_on_clr);
    chk("can_on", 1'h0, can_on_q);
    chk("tx_en", 1'h0, can_tx_en_q);
    end_of_test();
  end
  initial begin
    repeat (3000) @(posedge clock);
    mismatches++;
    end_of_test();
  end
endmodule // testbench
